// ==== rtl/fault_timing_pkg.sv ====
/*
 * constants, field layouts and carrier types for the fault timing block
 * assumes a 10 MHz mclk; long counts are overridable at the top level
 */
package fault_timing_pkg;

    // clock
    localparam int CLK_PERIOD_NS = 100;

    // register addresses
    localparam logic [7:0] ADDR_CTRL1 = 8'h0a;
    localparam logic [7:0] ADDR_TIMING = 8'h0b;
    localparam logic [7:0] ADDR_OUT_MSB = 8'h04;

    // reset values
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] TIMING_RESET = 8'h00;

    // field positions
    localparam int FAULT_DELAY_BIT = 3;
    localparam int RETRY_DELAY_BIT = 2;
    localparam int LATCH_CLEAR_BIT = 4;

    // gain stage function codes
    localparam logic [2:0] FUNC_NORMAL = 3'h0;
    localparam logic [2:0] FUNC_OPAMP = 3'h3;
    localparam logic [2:0] FUNC_COMPARATOR = 3'h7;

    // times
    localparam int QUAL_LONG_NS = 1000000;
    localparam int QUAL_SHORT_NS = 100000;
    localparam int RETRY_LONG_NS = 50000000;
    localparam int RETRY_SHORT_NS = 10000000;

    // cycle counts
    localparam int QUAL_LONG_CYC = QUAL_LONG_NS / CLK_PERIOD_NS;
    localparam int QUAL_SHORT_CYC = QUAL_SHORT_NS / CLK_PERIOD_NS;
    localparam int RETRY_LONG_CYC = RETRY_LONG_NS / CLK_PERIOD_NS;
    localparam int RETRY_SHORT_CYC = RETRY_SHORT_NS / CLK_PERIOD_NS;

    // timer width
    localparam int CNT_W = 20;

    // serial port
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h70;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef struct packed {
        logic [2:0] gainStageFunction;
        logic latchClear;
        logic shutdown;
        logic [2:0] channelSel;
    } ctrl1_t;

    typedef struct packed {
        logic [3:0] unusedHi;
        logic faultDelaySelect;
        logic retryDelaySelect;
        logic [1:0] unusedLo;
    } timing_cfg_t;

endpackage

// ==== rtl/fault_timer.sv ====
/*
 * fault qualification and retry timer driving the output stage
 * assumes senseAboveThr is already synchronised to mclk
 */
`timescale 1ns/1ps

module fault_timer #(
    parameter int QUAL_LONG = fault_timing_pkg::QUAL_LONG_CYC,
    parameter int QUAL_SHORT = fault_timing_pkg::QUAL_SHORT_CYC,
    parameter int RETRY_LONG = fault_timing_pkg::RETRY_LONG_CYC,
    parameter int RETRY_SHORT = fault_timing_pkg::RETRY_SHORT_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // configuration
    input wire fault_timing_pkg::ctrl1_t ctrl1,
    input wire fault_timing_pkg::timing_cfg_t timingCfg,
    // comparator level
    input wire logic senseAboveThr,
    // output stage
    output logic outDrive,
    output logic regulateEn
);
    typedef enum logic [1:0] {F_IDLE, F_QUAL, F_LATCH} fstate_t;

    localparam int W = fault_timing_pkg::CNT_W;
    localparam logic [W-1:0] QL = W'(QUAL_LONG - 1);
    localparam logic [W-1:0] QS = W'(QUAL_SHORT - 1);
    localparam logic [W-1:0] RL = W'(RETRY_LONG - 1);
    localparam logic [W-1:0] RS = W'(RETRY_SHORT - 1);

    fstate_t state_ff;
    logic [W-1:0] cnt_ff;
    logic [W-1:0] qualEnd;
    logic [W-1:0] retryEnd;
    logic timed;
    logic isOpamp;

    assign qualEnd = timingCfg.faultDelaySelect ? QS : QL;
    assign retryEnd = timingCfg.retryDelaySelect ? RS : RL;
    assign isOpamp = ctrl1.gainStageFunction == fault_timing_pkg::FUNC_OPAMP;
    assign timed = !ctrl1.shutdown && (isOpamp ||
        ctrl1.gainStageFunction == fault_timing_pkg::FUNC_COMPARATOR);

    // timing state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= F_IDLE;
            cnt_ff <= '0;
        end else if (!timed) begin
            state_ff <= F_IDLE;
            cnt_ff <= '0;
        end else begin
            case (state_ff)
                F_IDLE: begin
                    cnt_ff <= '0;
                    if (senseAboveThr) begin
                        state_ff <= F_QUAL;
                    end
                end
                F_QUAL: begin
                    if (!senseAboveThr) begin
                        state_ff <= F_IDLE;
                        cnt_ff <= '0;
                    end else if (cnt_ff >= qualEnd) begin
                        state_ff <= F_LATCH;
                        cnt_ff <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                F_LATCH: begin
                    if (ctrl1.latchClear) begin
                        state_ff <= F_IDLE;
                        cnt_ff <= '0;
                    end else if (cnt_ff >= retryEnd) begin
                        state_ff <= F_IDLE;
                        cnt_ff <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                default: begin
                    state_ff <= F_IDLE;
                    cnt_ff <= '0;
                end
            endcase
        end
    end

    // output stage
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            outDrive <= 1'b0;
            regulateEn <= 1'b0;
        end else if (ctrl1.shutdown) begin
            outDrive <= 1'b0;
            regulateEn <= 1'b0;
        end else if (ctrl1.gainStageFunction == fault_timing_pkg::FUNC_NORMAL)
        begin
            outDrive <= senseAboveThr;
            regulateEn <= 1'b0;
        end else if (timed) begin
            outDrive <= state_ff == F_QUAL && cnt_ff >= qualEnd
                && senseAboveThr
                || state_ff == F_LATCH && !ctrl1.latchClear
                && cnt_ff < retryEnd;
            regulateEn <= isOpamp && senseAboveThr
                && state_ff != F_LATCH;
        end else begin
            outDrive <= 1'b0;
            regulateEn <= 1'b0;
        end
    end

endmodule

// ==== rtl/fault_delay_retry_timing.sv ====
/*
 * two-wire register port, control registers and fault timer
 * assumes rst comes from a supply monitor and sclIn, sdaIn and
 * senseAboveThr arrive asynchronously from pins or analogue logic
 */
// Overview of operation
// - The timing register is eight host-read/write bits whose unused bits 7..4 and 1..0 the host writes as zero.
// - The timing register settings govern the delay before the output asserts on a fault.
// - Timing bit 3 picks the qualification delay, 0 for 1ms and 1 for 100us.
// - Timing bit 2 picks how long the output stays latched, 0 for 50ms and 1 for 10ms.
// - At power-up every register takes a defined state, the timing register all zeros.
// - Power-on reset holds the registers until the supply passes 2.4V, then releases them.
// - Function code 111 makes the gain stage a comparator doing on/off disconnect.
// - As comparator the output stays low until the sense level exceeds threshold for the delay, latches high for the retry time, then goes low.
// - In op-amp code 011 the output regulates for the delay, then latches high for the retry time, then goes low.
// - Writing 1 to bit 4 of the first control register releases a latched output and the bit clears itself.
// - Function code 000 is plain amplifier or comparator operation with no delay or latching.
`timescale 1ns/1ps

module fault_delay_retry_timing #(
    parameter logic [6:0] SLAVE_ADDR = fault_timing_pkg::SLAVE_ADDR_DEFAULT,
    parameter int QUAL_LONG = fault_timing_pkg::QUAL_LONG_CYC,
    parameter int RETRY_LONG = fault_timing_pkg::RETRY_LONG_CYC,
    parameter int RETRY_SHORT = fault_timing_pkg::RETRY_SHORT_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // two-wire port
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // analogue side
    input wire logic senseAboveThr,
    output logic outDrive,
    output logic regulateEn
);
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ACKA, S_PTR, S_ACKP, S_WR, S_ACKW, S_RD, S_RACK
    } sstate_t;

    logic sclMeta_ff, sclS_ff, sclD_ff;
    logic sdaMeta_ff, sdaS_ff, sdaD_ff;
    logic aboveMeta_ff, aboveS_ff;
    logic startCond, stopCond, sclRise, sclFall;
    sstate_t state_ff;
    logic [7:0] shift_ff;
    logic [3:0] bitCnt_ff;
    logic [7:0] ptr_ff;
    logic isRead_ff;
    logic wrStrobe_ff;
    logic [7:0] wrAddr_ff;
    logic [7:0] wrData_ff;
    logic [7:0] rdData;
    fault_timing_pkg::ctrl1_t ctrl1_ff;
    fault_timing_pkg::timing_cfg_t timing_ff;

    // input synchronisers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclMeta_ff <= 1'b1;
            sclS_ff <= 1'b1;
            sclD_ff <= 1'b1;
            sdaMeta_ff <= 1'b1;
            sdaS_ff <= 1'b1;
            sdaD_ff <= 1'b1;
            aboveMeta_ff <= 1'b0;
            aboveS_ff <= 1'b0;
        end else begin
            sclMeta_ff <= sclIn;
            sclS_ff <= sclMeta_ff;
            sclD_ff <= sclS_ff;
            sdaMeta_ff <= sdaIn;
            sdaS_ff <= sdaMeta_ff;
            sdaD_ff <= sdaS_ff;
            aboveMeta_ff <= senseAboveThr;
            aboveS_ff <= aboveMeta_ff;
        end
    end

    assign startCond = sclS_ff && sdaD_ff && !sdaS_ff;
    assign stopCond = sclS_ff && !sdaD_ff && sdaS_ff;
    assign sclRise = sclS_ff && !sclD_ff;
    assign sclFall = !sclS_ff && sclD_ff;

    // open-drain data line, only ever pulled low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sdaOut <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
        end
    end

    // serial byte engine
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= S_IDLE;
            shift_ff <= 8'h00;
            bitCnt_ff <= 4'h0;
            ptr_ff <= 8'h00;
            isRead_ff <= 1'b0;
            sdaOe <= 1'b0;
            wrStrobe_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
            wrData_ff <= 8'h00;
        end else begin
            wrStrobe_ff <= 1'b0;
            if (startCond) begin
                state_ff <= S_ADDR;
                bitCnt_ff <= 4'h0;
                sdaOe <= 1'b0;
            end else if (stopCond) begin
                state_ff <= S_IDLE;
                sdaOe <= 1'b0;
            end else begin
                case (state_ff)
                    S_ADDR, S_PTR, S_WR: begin
                        if (sclRise) begin
                            shift_ff <= {shift_ff[6:0], sdaS_ff};
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end else if (sclFall && bitCnt_ff ==
                            fault_timing_pkg::BITS_PER_BYTE) begin
                            sdaOe <= 1'b1;
                            if (state_ff == S_ADDR) begin
                                if (shift_ff[7:1] == SLAVE_ADDR) begin
                                    isRead_ff <= shift_ff[0];
                                    state_ff <= S_ACKA;
                                end else begin
                                    sdaOe <= 1'b0;
                                    state_ff <= S_IDLE;
                                end
                            end else if (state_ff == S_PTR) begin
                                ptr_ff <= shift_ff;
                                state_ff <= S_ACKP;
                            end else begin
                                wrStrobe_ff <= 1'b1;
                                wrAddr_ff <= ptr_ff;
                                wrData_ff <= shift_ff;
                                state_ff <= S_ACKW;
                            end
                        end
                    end
                    S_ACKA: begin
                        if (sclFall) begin
                            bitCnt_ff <= 4'h0;
                            if (isRead_ff) begin
                                shift_ff <= rdData;
                                sdaOe <= !rdData[7];
                                state_ff <= S_RD;
                            end else begin
                                sdaOe <= 1'b0;
                                state_ff <= S_PTR;
                            end
                        end
                    end
                    S_ACKP, S_ACKW: begin
                        if (sclFall) begin
                            sdaOe <= 1'b0;
                            bitCnt_ff <= 4'h0;
                            state_ff <= S_WR;
                            if (state_ff == S_ACKW) begin
                                ptr_ff <= ptr_ff + 8'h01;
                            end
                        end
                    end
                    S_RD: begin
                        if (sclRise) begin
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end else if (sclFall) begin
                            if (bitCnt_ff == fault_timing_pkg::BITS_PER_BYTE)
                            begin
                                sdaOe <= 1'b0;
                                state_ff <= S_RACK;
                            end else begin
                                shift_ff <= {shift_ff[6:0], 1'b0};
                                sdaOe <= !shift_ff[6];
                            end
                        end
                    end
                    S_RACK: begin
                        if (sclRise) begin
                            if (sdaS_ff) begin
                                state_ff <= S_IDLE;
                            end else begin
                                ptr_ff <= ptr_ff + 8'h01;
                            end
                        end else if (sclFall) begin
                            bitCnt_ff <= 4'h0;
                            shift_ff <= rdData;
                            sdaOe <= !rdData[7];
                            state_ff <= S_RD;
                        end
                    end
                    default: begin
                        sdaOe <= 1'b0;
                        state_ff <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // control registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl1_ff <= fault_timing_pkg::CTRL1_RESET;
            timing_ff <= fault_timing_pkg::TIMING_RESET;
        end else begin
            ctrl1_ff.latchClear <= 1'b0;
            if (wrStrobe_ff && wrAddr_ff == fault_timing_pkg::ADDR_CTRL1) begin
                ctrl1_ff <= wrData_ff;
            end
            if (wrStrobe_ff && wrAddr_ff == fault_timing_pkg::ADDR_TIMING)
            begin
                timing_ff <= wrData_ff;
            end
        end
    end

    // read selection
    always_comb begin
        case (ptr_ff)
            fault_timing_pkg::ADDR_CTRL1: rdData = ctrl1_ff;
            fault_timing_pkg::ADDR_TIMING: rdData = timing_ff;
            fault_timing_pkg::ADDR_OUT_MSB: rdData = {outDrive, 7'h00};
            default: rdData = 8'h00;
        endcase
    end

    fault_timer #(
        .QUAL_LONG(QUAL_LONG),
        .QUAL_SHORT(fault_timing_pkg::QUAL_SHORT_CYC),
        .RETRY_LONG(RETRY_LONG),
        .RETRY_SHORT(RETRY_SHORT)
    ) timerInst (
        .mclk(mclk),
        .rst(rst),
        .ctrl1(ctrl1_ff),
        .timingCfg(timing_ff),
        .senseAboveThr(aboveS_ff),
        .outDrive(outDrive),
        .regulateEn(regulateEn)
    );

endmodule

// ==== testbench/fault_timing_sva.sv ====
/*
 * port assertions for the fault timing block
 * assumes a single mclk domain with active high async rst
 */
`timescale 1ns/1ps

module fault_timing_sva #(
    parameter int RETRY_LONG = 500000
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // two-wire port
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // analogue side
    input wire logic senseAboveThr,
    input wire logic outDrive,
    input wire logic regulateEn
);
    int hiCnt;

    // length of the current high stretch
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hiCnt <= 0;
        end else begin
            hiCnt <= outDrive ? hiCnt + 1 : 0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_reset_quiet;
        disable iff (1'b0) rst |-> !outDrive && !regulateEn && !sdaOe;
    endproperty
    property p_release_quiet;
        $fell(rst) |-> !outDrive && !sdaOe ##1 !outDrive;
    endproperty
    property p_rise_needs_fault;
        $rose(outDrive) |-> $past(senseAboveThr, 3);
    endproperty
    property p_latch_hold;
        $rose(outDrive) |-> outDrive [*8];
    endproperty
    property p_retry_bound;
        hiCnt <= RETRY_LONG + 4;
    endproperty
    property p_no_reg_latched;
        outDrive |=> !regulateEn;
    endproperty
    property p_reg_needs_fault;
        $rose(regulateEn) |-> $past(senseAboveThr, 3);
    endproperty
    property p_sda_stands;
        $changed(sdaOe) |-> !sclIn;
    endproperty
    property p_sda_low;
        !sdaOut;
    endproperty

    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active during reset");
    a_release_quiet: assert property (p_release_quiet)
        else $error("outputs active after reset release");
    a_rise_needs_fault: assert property (p_rise_needs_fault)
        else $error("output rose without sense above threshold");
    a_latch_hold: assert property (p_latch_hold)
        else $error("output dropped too soon after rising");
    a_retry_bound: assert property (p_retry_bound)
        else $error("output held past the retry interval");
    a_no_reg_latched: assert property (p_no_reg_latched)
        else $error("regulating while output latched");
    a_reg_needs_fault: assert property (p_reg_needs_fault)
        else $error("regulating without sense above threshold");
    a_sda_stands: assert property (p_sda_stands)
        else $error("data drive changed while clock high");
    a_sda_low: assert property (p_sda_low)
        else $error("data line drive value not low");

    c_out_rise: cover property ($rose(outDrive));
    c_reg_rise: cover property ($rose(regulateEn));
    c_ack: cover property ($rose(sdaOe));
endmodule

bind fault_delay_retry_timing fault_timing_sva #(
    .RETRY_LONG(RETRY_LONG)
) chk_u (
    .mclk(mclk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .senseAboveThr(senseAboveThr),
    .outDrive(outDrive),
    .regulateEn(regulateEn)
);

// ==== testbench/i2c_host_model.sv ====
/*
 * two-wire bus master model issuing register transfers
 * assumes a pull-up on the data wire and the device open drain
 */
`timescale 1ns/1ps

module i2c_host_model #(
    parameter int HALF = 10
) (
    // clock
    input wire logic mclk,
    // bus
    input wire logic devPull,
    output logic scl,
    output logic sdaWire
);
    logic hostPull = 1'b0;

    assign sdaWire = !(hostPull || devPull);
    initial scl = 1'b1;

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic start_cond();
        hostPull = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        hostPull = 1'b1;
        tick(HALF);
        scl = 1'b0;
        tick(HALF);
    endtask

    task automatic stop_cond();
        hostPull = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        hostPull = 1'b0;
        tick(HALF);
    endtask

    task automatic put_bit(input logic b, output logic seen);
        hostPull = !b;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        seen = sdaWire;
        scl = 1'b0;
        tick(HALF);
    endtask

    task automatic put_byte(input logic [7:0] b, output logic [7:0] got,
            output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], got[i]);
        end
        put_bit(1'b1, s);
        ack = !s;
    endtask

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
            input logic [7:0] val, output logic ok);
        logic [7:0] g;
        logic a0;
        logic a1;
        logic a2;
        start_cond();
        put_byte({dev, 1'b0}, g, a0);
        put_byte(ptr, g, a1);
        put_byte(val, g, a2);
        stop_cond();
        ok = a0 && a1 && a2;
    endtask

    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
            output logic [7:0] val, output logic ok);
        logic [7:0] g;
        logic a0;
        logic a1;
        logic a2;
        start_cond();
        put_byte({dev, 1'b0}, g, a0);
        put_byte(ptr, g, a1);
        start_cond();
        put_byte({dev, 1'b1}, g, a2);
        put_byte(8'hff, val, g[0]);
        stop_cond();
        ok = a0 && a1 && a2;
    endtask
endmodule

// ==== testbench/tb.sv ====
/*
 * self-checking bench for the fault timing block
 * assumes the host model for all register traffic
 */
`timescale 1ns/1ps

module tb;
    localparam int QL = 20;
    localparam int RL = 2000;
    localparam int RS = 30;
    localparam int QS = fault_timing_pkg::QUAL_SHORT_CYC;
    localparam logic [6:0] DEV = fault_timing_pkg::SLAVE_ADDR_DEFAULT;
    localparam logic [7:0] TREG = fault_timing_pkg::ADDR_TIMING;
    localparam logic [7:0] CREG = fault_timing_pkg::ADDR_CTRL1;

    logic mclk = 1'b1;
    logic rst = 1'b0;
    logic sense = 1'b0;
    logic scl;
    logic sda;
    logic sdaOut;
    logic sdaOe;
    logic outDrive;
    logic regulateEn;
    int miscompares = 0;
    int nTests = 0;
    int cycleCnt = 0;

    fault_delay_retry_timing #(.QUAL_LONG(QL), .RETRY_LONG(RL),
        .RETRY_SHORT(RS)) dut_u (.mclk(mclk), .rst(rst), .sclIn(scl),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .senseAboveThr(sense), .outDrive(outDrive),
        .regulateEn(regulateEn));
    i2c_host_model host_u (.mclk(mclk), .devPull(sdaOe), .scl(scl),
        .sdaWire(sda));

    initial forever #50 mclk = ~mclk;

    task automatic tallyAndFinish();
        $display("comparisons %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycleCnt++;
        if (cycleCnt == 60000) begin
            miscompares++;
            tallyAndFinish();
        end
    end

    task automatic check(input string what, input logic [7:0] seen,
            input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    function automatic logic inr(int n, int lo, int hi);
        return n >= lo && n <= hi;
    endfunction

    task automatic wr(input logic [7:0] p, input logic [7:0] v);
        logic ok;
        host_u.write_reg(DEV, p, v, ok);
        check("write ack", ok, 1'b1);
    endtask

    task automatic rd(input logic [7:0] p, input logic [7:0] e,
            input string what);
        logic ok;
        logic [7:0] v;
        host_u.read_reg(DEV, p, v, ok);
        check("read ack", ok, 1'b1);
        check(what, v, e);
    endtask

    task automatic wait_out(input logic v, input int lim, output int n);
        n = 0;
        while (outDrive !== v && n < lim) begin
            @(negedge mclk);
            n++;
        end
    endtask

    task automatic t_reset();
        check("out at reset", outDrive, 1'b0);
        rd(TREG, 8'h00, "timing reset");
        rd(CREG, 8'h00, "ctrl1 reset");
    endtask

    task automatic t_regs();
        logic ok;
        wr(TREG, 8'h0c);
        rd(TREG, 8'h0c, "timing rw");
        host_u.write_reg(7'h11, TREG, 8'h08, ok);
        check("foreign ack", ok, 1'b0);
        rd(TREG, 8'h0c, "timing kept");
        rd(8'h20, 8'h00, "unmapped read");
        wr(TREG, 8'h00);
    endtask

    task automatic t_normal();
        sense = 1'b1;
        repeat (6) @(negedge mclk);
        check("follow high", outDrive, 1'b1);
        rd(fault_timing_pkg::ADDR_OUT_MSB, 8'h80, "out readback");
        repeat (6) @(negedge mclk);
        sense = 1'b0;
        repeat (6) @(negedge mclk);
        check("follow low", outDrive, 1'b0);
    endtask

    task automatic t_comp();
        int n;
        wr(CREG, 8'he0);
        sense = 1'b1;
        repeat (QL - 5) @(negedge mclk);
        sense = 1'b0;
        repeat (5) @(negedge mclk);
        sense = 1'b1;
        repeat (QL - 5) @(negedge mclk);
        check("qual restart", outDrive, 1'b0);
        wait_out(1'b1, 20, n);
        check("qual long", inr(n, 3, 11), 1'b1);
        wait_out(1'b0, RL + 10, n);
        check("retry long", inr(n, RL - 2, RL + 2), 1'b1);
        wait_out(1'b1, QL + 10, n);
        check("requalify", inr(n, QL - 2, QL + 4), 1'b1);
        sense = 1'b0;
        wr(CREG, 8'hf0);
        check("clear release", outDrive, 1'b0);
        rd(CREG, 8'he0, "clear self");
        wr(TREG, 8'h0c);
        sense = 1'b1;
        wait_out(1'b1, QS + 20, n);
        check("qual short", inr(n, QS, QS + 6), 1'b1);
        wait_out(1'b0, RS + 10, n);
        check("retry short", inr(n, RS - 2, RS + 2), 1'b1);
        sense = 1'b0;
    endtask

    task automatic t_opamp();
        int n;
        wr(CREG, 8'h60);
        wr(TREG, 8'h04);
        sense = 1'b1;
        repeat (6) @(negedge mclk);
        check("regulating", {regulateEn, outDrive}, 2'b10);
        wait_out(1'b1, QL + 10, n);
        sense = 1'b0;
        @(negedge mclk);
        check("latch stops reg", regulateEn, 1'b0);
        wait_out(1'b0, RS + 10, n);
        check("opamp retry", inr(n, RS - 3, RS + 2), 1'b1);
        wr(CREG, 8'h68);
        sense = 1'b1;
        repeat (QL + 10) @(negedge mclk);
        check("shutdown quiet", {regulateEn, outDrive}, 2'b00);
        sense = 1'b0;
        repeat (6) @(negedge mclk);
    endtask

    task automatic t_por();
        wr(TREG, 8'h0c);
        @(negedge mclk);
        rst = 1'b1;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        repeat (5) @(negedge mclk);
        check("out after reset", outDrive, 1'b0);
        rd(TREG, 8'h00, "timing after reset");
        rd(CREG, 8'h00, "ctrl1 after reset");
    endtask

    initial begin
        @(negedge mclk);
        rst = 1'b1;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        repeat (5) @(negedge mclk);
        t_reset();
        t_regs();
        t_normal();
        t_comp();
        t_opamp();
        t_por();
        tallyAndFinish();
    end
endmodule
